/* File: hdl/crpm_regs.vh */
// Register indices, field masks and reset values of the clock, reset and power unit
//
// Contract
// - A low level on the reset pin forces all logic except the reset pin driver and the reset cause flags to its start state at once, without a clock.
// - Any internal reset source pulls the reset pin low through an open-drain driver.
// - The oscillator clock is derived from the level seen on the crystal input pin.
// - While the oscillator enable bit is clear both crystal pins get weak pull-downs.
// - The periodic clock pin carries the selected signal and is driven only while enabled.
// - Internal clocks reach the test clock pin only while the test clock enable bit is set.
// - The trim-load strobe loads the core and flash supply trims, which drive the regulator.
// - Multiplier and reference divider writes act only with protection clear and PLL selected.
// - An accepted multiplier write clears the lock and oscillator-up status bits.
`ifndef CRPM_REGS_VH
`define CRPM_REGS_VH

// Register indices; byte address is four times the index
`define CRPM_IDX_SYNR 10'h034
`define CRPM_IDX_REFDIV 10'h035
`define CRPM_IDX_POSTDIV 10'h036
`define CRPM_IDX_FLG 10'h037
`define CRPM_IDX_INT 10'h038
`define CRPM_IDX_CLKS 10'h039
`define CRPM_IDX_PLL 10'h03a
`define CRPM_IDX_RTI 10'h03b
`define CRPM_IDX_COP 10'h03c
`define CRPM_IDX_TEST0 10'h03d
`define CRPM_IDX_TEST1 10'h03e
`define CRPM_IDX_SERVICE 10'h03f
`define CRPM_IDX_GAP 10'h2f0
`define CRPM_IDX_LVCTL 10'h2f1
`define CRPM_IDX_APICTL 10'h2f2
`define CRPM_IDX_APITR 10'h2f3
`define CRPM_IDX_APIRH 10'h2f4
`define CRPM_IDX_APIRL 10'h2f5
`define CRPM_IDX_REGTEST 10'h2f6
`define CRPM_IDX_OSC 10'h2fa
`define CRPM_IDX_WRITE_PROTECT_BIT 10'h2fb

// Writable bit masks
`define CRPM_MSK_REFDIV 8'hcf
`define CRPM_MSK_POSTDIV 8'h1f
`define CRPM_MSK_INT 8'h92
`define CRPM_MSK_CLKS 8'hcf
`define CRPM_MSK_PLL 8'h30
`define CRPM_MSK_COP 8'hc7
`define CRPM_MSK_LVCTL 8'h02
`define CRPM_MSK_APICTL 8'h9e
`define CRPM_MSK_APITR 8'hfc
`define CRPM_MSK_FLG_W1C 8'h76

// Reset values
`define CRPM_RST_REFDIV 8'h0f
`define CRPM_RST_POSTDIV 8'h03
`define CRPM_RST_CLKS 8'h80

// Field positions
`define CRPM_BIT_PLL_CLOCK_SELECT 7
`define CRPM_BIT_OSCE 7
`define CRPM_BIT_PERIODIC_OUTPUT_SELECT 4
`define CRPM_BIT_PERIODIC_OUTPUT_ENABLE 3
`define CRPM_BIT_APIFE 2
`define CRPM_BIT_APIF 0
`define CRPM_BIT_TCLK_EN 6
`define CRPM_BIT_WRITE_PROTECT_BIT 0

// Reset source vector positions
`define CRPM_SRC_POR 0
`define CRPM_SRC_LVR 1
`define CRPM_SRC_ILA 2

`endif

/* File: hdl/crpm_top.v */
// Clock, reset and power unit register bank with its pin-level logic
//
// Implementation choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "crpm_regs.vh"

module crpm_top (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire reset_pin_in,
   output reg reset_pin_out,
   output reg reset_pin_oe,
   input wire [4:0] reset_sources,
   input wire crystal_input_pin,
   output reg crystal_input_pulldown,
   output reg crystal_output_pulldown,
   output reg oscillator_clock,
   input wire pll_locked_in,
   input wire osc_up_in,
   output reg periodic_clock_output_pin,
   output reg periodic_clock_output_oe,
   output reg test_clock_out,
   input wire trim_load_strobe,
   input wire [2:0] core_trim_in,
   input wire [2:0] flash_trim_in,
   output reg [2:0] core_supply_trim,
   output reg [2:0] flash_supply_trim,
   output reg pll_clock_select
);

   // Internal reset: asserts at once from either source, releases on the clock
   wire rst_raw_n, rst_n;
   reg rst_meta_reg, rst_sync_reg;

   assign rst_raw_n = presetn & reset_pin_in;
   assign rst_n = rst_sync_reg;

   always @(posedge pclk or negedge rst_raw_n)
   begin
      if (!rst_raw_n)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // Open-drain reset driver and reset cause flags, untouched by pin resets
   reg porf_reg, lvrf_reg, ilaf_reg;
   wire flg_clr_w;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reset_pin_out <= 1'b0;
         reset_pin_oe <= 1'b0;
         porf_reg <= 1'b0;
         lvrf_reg <= 1'b0;
         ilaf_reg <= 1'b0;
      end
      else
      begin
         reset_pin_out <= 1'b0;
         reset_pin_oe <= |reset_sources;
         // Set wins over a software clear
         porf_reg <= reset_sources[`CRPM_SRC_POR] | (porf_reg & ~(flg_clr_w & pwdata[6]));
         lvrf_reg <= reset_sources[`CRPM_SRC_LVR] | reset_sources[`CRPM_SRC_POR] |
            (lvrf_reg & ~(flg_clr_w & pwdata[5]));
         ilaf_reg <= reset_sources[`CRPM_SRC_ILA] | (ilaf_reg & ~(flg_clr_w & pwdata[2]));
      end
   end

   // Three-stage sampling of outside levels; a change counts once the second and third stages agree
   reg [2:0] smp1_reg, smp2_reg, smp3_reg;
   reg [2:0] filt_reg, filt_prev_reg;

   always @(posedge pclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         smp1_reg <= 3'h0;
         smp2_reg <= 3'h0;
         smp3_reg <= 3'h0;
         filt_reg <= 3'h0;
         filt_prev_reg <= 3'h0;
      end
      else
      begin
         smp1_reg <= {osc_up_in, pll_locked_in, crystal_input_pin};
         smp2_reg <= smp1_reg;
         smp3_reg <= smp2_reg;
         filt_reg <= (smp2_reg & smp3_reg) | (filt_reg & (smp2_reg | smp3_reg));
         filt_prev_reg <= filt_reg;
      end
   end

   // Register storage; the first test row keeps nothing, so writes to it vanish
   reg [7:0] synr_reg, refdiv_reg, postdiv_reg, int_reg, clks_reg, pll_reg, rti_reg;
   reg [7:0] cop_reg, test1_reg, lvctl_reg, apictl_reg, apitr_reg, apirh_reg, apirl_reg;
   reg [7:0] osc_reg;
   reg write_protect_bit_reg, lock_reg, oscillator_up_status_reg, lockif_reg, oscif_reg;
   reg [15:0] api_cnt_reg;
   reg api_tick_reg, api_clk_reg, div2_reg;

   // Bus decode
   wire [9:0] idx;
   wire [7:0] wd;
   wire wr_en, pll_wr_ok, pll_wr_clr, api_hit;

   assign idx = paddr[11:2];
   assign wd = pwdata[7:0];
   assign wr_en = psel & penable & pwrite & pready & ~pslverr;
   assign pll_wr_ok = ~write_protect_bit_reg & clks_reg[`CRPM_BIT_PLL_CLOCK_SELECT];
   assign pll_wr_clr = wr_en & pll_wr_ok &
      ((idx == `CRPM_IDX_SYNR) | (idx == `CRPM_IDX_REFDIV));
   assign flg_clr_w = wr_en & (idx == `CRPM_IDX_FLG);
   assign api_hit = (api_cnt_reg == {apirh_reg, apirl_reg});

   // Register writes
   always @(posedge pclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         synr_reg <= 8'h00;
         refdiv_reg <= `CRPM_RST_REFDIV;
         postdiv_reg <= `CRPM_RST_POSTDIV;
         int_reg <= 8'h00;
         clks_reg <= `CRPM_RST_CLKS;
         pll_reg <= 8'h00;
         rti_reg <= 8'h00;
         cop_reg <= 8'h00;
         test1_reg <= 8'h00;
         lvctl_reg <= 8'h00;
         apitr_reg <= 8'h00;
         apirh_reg <= 8'h00;
         apirl_reg <= 8'h00;
         osc_reg <= 8'h00;
         write_protect_bit_reg <= 1'b0;
      end
      else if (wr_en)
      begin
         // Masks keep reserved bits at zero
         case (idx)
            `CRPM_IDX_SYNR: if (pll_wr_ok) synr_reg <= wd;
            `CRPM_IDX_REFDIV: if (pll_wr_ok) refdiv_reg <= wd & `CRPM_MSK_REFDIV;
            `CRPM_IDX_POSTDIV:
            begin
               if (clks_reg[`CRPM_BIT_PLL_CLOCK_SELECT])
                  postdiv_reg <= wd & `CRPM_MSK_POSTDIV;
            end
            `CRPM_IDX_INT: int_reg <= wd & `CRPM_MSK_INT;
            `CRPM_IDX_CLKS: clks_reg <= wd & `CRPM_MSK_CLKS;
            `CRPM_IDX_PLL: pll_reg <= wd & `CRPM_MSK_PLL;
            `CRPM_IDX_RTI: rti_reg <= wd;
            `CRPM_IDX_COP: cop_reg <= wd & `CRPM_MSK_COP;
            `CRPM_IDX_TEST1: test1_reg <= wd;
            `CRPM_IDX_LVCTL: lvctl_reg <= wd & `CRPM_MSK_LVCTL;
            `CRPM_IDX_APITR: apitr_reg <= wd & `CRPM_MSK_APITR;
            `CRPM_IDX_APIRH: apirh_reg <= wd;
            `CRPM_IDX_APIRL: apirl_reg <= wd;
            `CRPM_IDX_OSC: osc_reg <= wd;
            `CRPM_IDX_WRITE_PROTECT_BIT: write_protect_bit_reg <= wd[`CRPM_BIT_WRITE_PROTECT_BIT];
            default: write_protect_bit_reg <= write_protect_bit_reg;
         endcase
      end
   end

   // Status flags; a hardware set wins over a clear in the same cycle
   always @(posedge pclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lock_reg <= 1'b0;
         oscillator_up_status_reg <= 1'b0;
         lockif_reg <= 1'b0;
         oscif_reg <= 1'b0;
      end
      else
      begin
         lock_reg <= (filt_reg[1] & ~filt_prev_reg[1]) | (lock_reg & ~pll_wr_clr);
         oscillator_up_status_reg <= (filt_reg[2] & ~filt_prev_reg[2]) | (oscillator_up_status_reg & ~pll_wr_clr);
         lockif_reg <= (filt_reg[1] ^ filt_prev_reg[1]) | (lockif_reg & ~(flg_clr_w & wd[4]));
         oscif_reg <= (filt_reg[2] ^ filt_prev_reg[2]) | (oscif_reg & ~(flg_clr_w & wd[1]));
      end
   end

   // Autonomous periodic timer and its control register
   always @(posedge pclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         api_cnt_reg <= 16'h0000;
         api_tick_reg <= 1'b0;
         api_clk_reg <= 1'b0;
         apictl_reg <= 8'h00;
         div2_reg <= 1'b0;
      end
      else
      begin
         div2_reg <= ~div2_reg;
         api_tick_reg <= 1'b0;
         if (!apictl_reg[`CRPM_BIT_APIFE])
            api_cnt_reg <= 16'h0000;
         else if (api_hit)
         begin
            api_cnt_reg <= 16'h0000;
            api_tick_reg <= 1'b1;
            api_clk_reg <= ~api_clk_reg;
         end
         else
            api_cnt_reg <= api_cnt_reg + 16'h0001;
         if (wr_en && (idx == `CRPM_IDX_APICTL))
            apictl_reg <= (wd & `CRPM_MSK_APICTL) |
               {7'h00, api_tick_reg | (apictl_reg[`CRPM_BIT_APIF] & ~wd[`CRPM_BIT_APIF])};
         else
            apictl_reg[`CRPM_BIT_APIF] <= apictl_reg[`CRPM_BIT_APIF] | api_tick_reg;
      end
   end

   // Pin outputs and trims
   reg tclk_sel;

   always @*
   begin
      case (test1_reg[5:4])
         2'b00: tclk_sel = filt_reg[0];
         2'b01: tclk_sel = api_clk_reg;
         2'b10: tclk_sel = div2_reg;
         default: tclk_sel = 1'b0;
      endcase
   end

   always @(posedge pclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         crystal_input_pulldown <= 1'b1;
         crystal_output_pulldown <= 1'b1;
         oscillator_clock <= 1'b0;
         periodic_clock_output_pin <= 1'b0;
         periodic_clock_output_oe <= 1'b0;
         test_clock_out <= 1'b0;
         core_supply_trim <= 3'h0;
         flash_supply_trim <= 3'h0;
         pll_clock_select <= 1'b1;
      end
      else
      begin
         crystal_input_pulldown <= ~osc_reg[`CRPM_BIT_OSCE];
         crystal_output_pulldown <= ~osc_reg[`CRPM_BIT_OSCE];
         oscillator_clock <= osc_reg[`CRPM_BIT_OSCE] & filt_reg[0];
         // Select 1: toggling clock, 0: one-cycle tick
         periodic_clock_output_pin <= apictl_reg[`CRPM_BIT_PERIODIC_OUTPUT_ENABLE] &
            (apictl_reg[`CRPM_BIT_PERIODIC_OUTPUT_SELECT] ? api_clk_reg : api_tick_reg);
         periodic_clock_output_oe <= apictl_reg[`CRPM_BIT_PERIODIC_OUTPUT_ENABLE];
         test_clock_out <= test1_reg[`CRPM_BIT_TCLK_EN] & tclk_sel;
         if (trim_load_strobe)
         begin
            core_supply_trim <= core_trim_in;
            flash_supply_trim <= flash_trim_in;
         end
         pll_clock_select <= clks_reg[`CRPM_BIT_PLL_CLOCK_SELECT];
      end
   end

   // Read mux; write-only and test rows read zero
   reg [7:0] rd_data;
   reg rd_hit;

   always @*
   begin
      rd_hit = 1'b1;
      rd_data = 8'h00;
      case (idx)
         `CRPM_IDX_SYNR: rd_data = synr_reg;
         `CRPM_IDX_REFDIV: rd_data = refdiv_reg;
         `CRPM_IDX_POSTDIV: rd_data = postdiv_reg;
         `CRPM_IDX_FLG:
            rd_data = {1'b0, porf_reg, lvrf_reg, lockif_reg, lock_reg, ilaf_reg, oscif_reg,
               oscillator_up_status_reg};
         `CRPM_IDX_INT: rd_data = int_reg;
         `CRPM_IDX_CLKS: rd_data = clks_reg;
         `CRPM_IDX_PLL: rd_data = pll_reg;
         `CRPM_IDX_RTI: rd_data = rti_reg;
         `CRPM_IDX_COP: rd_data = cop_reg;
         `CRPM_IDX_TEST0: rd_data = 8'h00;
         `CRPM_IDX_TEST1: rd_data = 8'h00;
         `CRPM_IDX_SERVICE: rd_data = 8'h00;
         `CRPM_IDX_GAP: rd_data = 8'h00;
         `CRPM_IDX_LVCTL: rd_data = lvctl_reg;
         `CRPM_IDX_APICTL: rd_data = apictl_reg;
         `CRPM_IDX_APITR: rd_data = apitr_reg;
         `CRPM_IDX_APIRH: rd_data = apirh_reg;
         `CRPM_IDX_APIRL: rd_data = apirl_reg;
         `CRPM_IDX_REGTEST: rd_data = {2'b00, flash_supply_trim, core_supply_trim};
         `CRPM_IDX_OSC: rd_data = osc_reg;
         `CRPM_IDX_WRITE_PROTECT_BIT: rd_data = {7'h00, write_protect_bit_reg};
         default: rd_hit = 1'b0;
      endcase
   end

   // APB answer: ready in the first access cycle, no wait states
   always @(posedge pclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else if (psel && !penable)
      begin
         prdata <= pwrite ? 32'h00000000 : {24'h000000, rd_data};
         pready <= 1'b1;
         pslverr <= ~rd_hit;
      end
      else
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

endmodule // crpm_top

`default_nettype wire

/* File: dv/crpm_top_properties.sv */
// Checker of bus and pin relations of the clock, reset and power unit
`timescale 1ns/1ns
`default_nettype none
module crpm_top_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic reset_pin_in,
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   input wire logic [4:0] reset_sources,
   input wire logic crystal_input_pulldown,
   input wire logic crystal_output_pulldown,
   input wire logic oscillator_clock,
   input wire logic periodic_clock_output_pin,
   input wire logic periodic_clock_output_oe,
   input wire logic trim_load_strobe,
   input wire logic [2:0] core_trim_in,
   input wire logic [2:0] flash_trim_in,
   input wire logic [2:0] core_supply_trim,
   input wire logic [2:0] flash_supply_trim,
   input wire logic pll_clock_select
);
   // Both reset inputs silence the checks, except the reset pin enable and pin reset checks
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn || !reset_pin_in);

   // Bus answer and reset pin driver
   AST_APB_ANSWER: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("no single answer cycle");
   // The driver lives through pin resets, so only presetn silences the first two
   AST_RST_OE: assert property (disable iff (!presetn) |reset_sources |=> reset_pin_oe)
      else $error("reset pin not pulled");
   AST_RST_OFF: assert property (disable iff (!presetn)
      !(|reset_sources) |=> !reset_pin_oe)
      else $error("reset pin pulled without source");
   AST_RST_OUT: assert property (reset_pin_oe |-> !reset_pin_out)
      else $error("reset pin driven high");
   // Crystal pins and oscillator clock
   AST_PULL_PAIR: assert property (crystal_input_pulldown == crystal_output_pulldown)
      else $error("pull-downs disagree");
   AST_PULL_OSC: assert property (crystal_input_pulldown [*2] |-> !oscillator_clock)
      else $error("oscillator runs while disabled");
   // Periodic output gated by its enable
   AST_API_OE: assert property (!periodic_clock_output_oe [*2] |->
      !periodic_clock_output_pin)
      else $error("periodic pin active while disabled");
   // Trim load and hold
   AST_TRIM: assert property (trim_load_strobe |=> core_supply_trim == $past(core_trim_in)
      && flash_supply_trim == $past(flash_trim_in))
      else $error("trim not loaded");
   AST_TRIM_HOLD: assert property (!trim_load_strobe |=> $stable(core_supply_trim)
      && $stable(flash_supply_trim))
      else $error("trim changed without strobe");
   // Pin reset forces start state at once
   AST_PIN_RESET: assert property (@(posedge pclk) disable iff (!presetn)
      !reset_pin_in |-> core_supply_trim == 3'h0 && pll_clock_select)
      else $error("pin reset not applied");

   cover property (reset_pin_oe);
   cover property (trim_load_strobe);
   cover property (periodic_clock_output_oe && periodic_clock_output_pin);
endmodule // crpm_top_properties
bind crpm_top crpm_top_properties u_props (.*);
`default_nettype wire

/* File: dv/crpm_board.sv */
// Board model: open-drain reset line and crystal source
`timescale 1ns/1ns
`default_nettype none
module crpm_board (
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   input wire logic board_reset_n,
   input wire logic crystal_input_pulldown,
   input wire logic crystal_output_pin_run,
   output logic reset_pin_in,
   output logic crystal_input_pin
);
   logic crystal_output_pin = 1'b0;
   // Pull-up line, low from board push or device driver
   assign reset_pin_in = board_reset_n & ~(reset_pin_oe & ~reset_pin_out);
   // Free-running crystal, unrelated to the bus clock
   always #26 crystal_output_pin = ~crystal_output_pin;
   // Stopped crystal: pulled low, else floating noise
   assign crystal_input_pin = crystal_output_pin_run ? crystal_output_pin : (~crystal_input_pulldown & crystal_output_pin);
endmodule // crpm_board
`default_nettype wire

/* File: dv/crpm_top_test.sv */
// Self-checking bench of the clock, reset and power unit
`timescale 1ns/1ns
`default_nettype none
`include "crpm_regs.vh"
module crpm_top_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [4:0] reset_sources = 5'h00;
   logic pll_locked_in = 1'b0;
   logic osc_up_in = 1'b0;
   logic trim_load_strobe = 1'b0;
   logic [2:0] core_trim_in = 3'h0;
   logic [2:0] flash_trim_in = 3'h0;
   logic board_reset_n = 1'b1;
   logic crystal_output_pin_run = 1'b0;
   logic [7:0] rdat;
   logic serr;
   int error_cnt = 0;
   int checked = 0;
   int n;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, reset_pin_in, reset_pin_out, reset_pin_oe, crystal_input_pin;
   wire logic crystal_input_pulldown, crystal_output_pulldown, oscillator_clock, test_clock_out;
   wire logic periodic_clock_output_pin, periodic_clock_output_oe, pll_clock_select;
   wire logic [2:0] core_supply_trim, flash_supply_trim;
   wire logic [2:0] mon = {test_clock_out, periodic_clock_output_pin, oscillator_clock};

   crpm_top uut (.*);
   crpm_board board (.*);

   // Bus clock
   initial forever #2 pclk = ~pclk;

   // Verdict and end of run
   task automatic report_and_stop();
      $display("Checks %0d, errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Count one comparison
   task automatic chk(input logic ok);
      checked++;
      if (ok !== 1'b1)
      begin
         error_cnt++;
         $display("Error %0t: mismatch", $time);
      end
   endtask

   // One APB transfer after an idle cycle
   task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 16);
      rdat = prdata[7:0];
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         error_cnt++;
         $display("Error %0t: no bus answer", $time);
         report_and_stop();
      end
   endtask

   // Register write and checked read
   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask
   task automatic rd(input logic [9:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 8'h00);
      chk(rdat === e);
   endtask

   // Idle cycles
   task automatic cyc(input int c);
      repeat (c) @(posedge pclk);
   endtask

   // Level changes of one monitored pin over 100 cycles
   task automatic cnt(input int i);
      logic p;
      n = 0;
      p = mon[i];
      repeat (100)
      begin
         @(posedge pclk);
         if (mon[i] !== p)
            n++;
         p = mon[i];
      end
   endtask

   // Reset values, masks, reserved and unmapped places
   task automatic t_map();
      rd(`CRPM_IDX_CLKS, `CRPM_RST_CLKS);
      rd(`CRPM_IDX_REFDIV, `CRPM_RST_REFDIV);
      rd(`CRPM_IDX_POSTDIV, `CRPM_RST_POSTDIV);
      wr(`CRPM_IDX_INT, 8'hff);
      rd(`CRPM_IDX_INT, `CRPM_MSK_INT);
      wr(`CRPM_IDX_SERVICE, 8'hff);
      rd(`CRPM_IDX_SERVICE, 8'h00);
      rd(10'h2f7, 8'h00);
      chk(serr === 1'b1);
   endtask

   // Protected multiplier writes and status clearing
   task automatic t_write_protect_bit();
      pll_locked_in <= 1'b1;
      osc_up_in <= 1'b1;
      cyc(8);
      rd(`CRPM_IDX_FLG, 8'h1b);
      wr(`CRPM_IDX_SYNR, 8'h55);
      rd(`CRPM_IDX_FLG, 8'h12);
      wr(`CRPM_IDX_WRITE_PROTECT_BIT, 8'h01);
      wr(`CRPM_IDX_SYNR, 8'haa);
      wr(`CRPM_IDX_REFDIV, 8'h00);
      rd(`CRPM_IDX_SYNR, 8'h55);
      rd(`CRPM_IDX_REFDIV, `CRPM_RST_REFDIV);
      wr(`CRPM_IDX_WRITE_PROTECT_BIT, 8'h00);
      wr(`CRPM_IDX_CLKS, 8'h00);
      wr(`CRPM_IDX_SYNR, 8'haa);
      rd(`CRPM_IDX_SYNR, 8'h55);
      chk(pll_clock_select === 1'b0);
      wr(`CRPM_IDX_CLKS, 8'h80);
      wr(`CRPM_IDX_SYNR, 8'haa);
      rd(`CRPM_IDX_SYNR, 8'haa);
   endtask

   // Crystal, periodic and test clock pins
   task automatic t_pins();
      crystal_output_pin_run <= 1'b1;
      chk(crystal_input_pulldown === 1'b1 && crystal_output_pulldown === 1'b1);
      cnt(0);
      chk(n === 0);
      wr(`CRPM_IDX_OSC, 8'h80);
      cyc(2);
      chk(crystal_input_pulldown === 1'b0 && crystal_output_pulldown === 1'b0);
      cnt(0);
      chk(n >= 14 && n <= 17);
      wr(`CRPM_IDX_APIRL, 8'h03);
      wr(`CRPM_IDX_APICTL, 8'h1c);
      cnt(1);
      chk(periodic_clock_output_oe === 1'b1 && n >= 24 && n <= 26);
      wr(`CRPM_IDX_APICTL, 8'h0c);
      cnt(1);
      chk(n >= 48 && n <= 52);
      wr(`CRPM_IDX_APICTL, 8'h14);
      cyc(2);
      cnt(1);
      chk(periodic_clock_output_oe === 1'b0 && n === 0);
      wr(`CRPM_IDX_TEST1, 8'h20);
      cnt(2);
      chk(n === 0);
      wr(`CRPM_IDX_TEST1, 8'h60);
      cnt(2);
      chk(n >= 98);
   endtask

   // Trim load, hold and read-back
   task automatic t_trim();
      core_trim_in <= 3'h5;
      flash_trim_in <= 3'h2;
      trim_load_strobe <= 1'b1;
      @(posedge pclk);
      trim_load_strobe <= 1'b0;
      core_trim_in <= 3'h7;
      flash_trim_in <= 3'h7;
      cyc(2);
      chk(core_supply_trim === 3'h5 && flash_supply_trim === 3'h2);
      rd(`CRPM_IDX_REGTEST, 8'h15);
   endtask

   // Board push and every internal reset source
   task automatic t_rst();
      board_reset_n <= 1'b0;
      #1;
      chk(core_supply_trim === 3'h0 && pll_clock_select === 1'b1);
      @(posedge pclk);
      board_reset_n <= 1'b1;
      cyc(4);
      for (int i = 0; i < 5; i++)
      begin
         wr(`CRPM_IDX_SYNR, 8'h3c);
         reset_sources <= 5'(1 << i);
         cyc(3);
         chk(reset_pin_oe === 1'b1 && reset_pin_in === 1'b0);
         reset_sources <= 5'h00;
         cyc(6);
         rd(`CRPM_IDX_SYNR, 8'h00);
      end
      // Reset cause flags survive pin resets and clear by writing ones
      rd(`CRPM_IDX_FLG, 8'h7f);
      wr(`CRPM_IDX_FLG, `CRPM_MSK_FLG_W1C);
      rd(`CRPM_IDX_FLG, 8'h09);
   endtask

   // Main sequence
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      cyc(3);
      t_map();
      t_write_protect_bit();
      t_pins();
      t_trim();
      t_rst();
      report_and_stop();
   end
endmodule // crpm_top_test
`default_nettype wire
